// [design/lftm_pkg.sv]
// package: shared constants and types for the lin frame trigger matcher
package lftm_pkg;
    // ----------------------------------------
    // setting ranges
    // ----------------------------------------
    localparam logic [6:0] ID_DONT_CARE = 7'h40; // identifier don't-care code
    localparam logic [6:0] ID_RESET = 7'h40; // identifier starts as don't-care
    localparam logic [8:0] BYTE_DONT_CARE = 9'h100; // data byte don't-care code
    localparam logic [8:0] BYTE_RESET = 9'h100; // bytes start as don't-care
    localparam logic [14:0] CUSTOM_MIN = 15'h012C; // 300 bit/s
    localparam logic [14:0] CUSTOM_MAX = 15'h4E20; // 20000 bit/s
    localparam logic [14:0] CUSTOM_RESET = 15'h2580; // 9600 bit/s
    // ----------------------------------------
    // clocking
    // ----------------------------------------
    localparam int CLK_HZ = 10000000; // system clock rate
    localparam int OVERSAMPLE = 16; // receiver samples per bit
    localparam logic [9:0] BREAK_BITS = 10'h00D; // dominant bits marking a break

    // ----------------------------------------
    // enumerations
    // ----------------------------------------
    typedef enum logic [2:0] { RATE_600, RATE_1200, RATE_2400, RATE_4800,
        RATE_9600, RATE_19200, RATE_CUSTOM } lftm_rate_t;
    typedef enum logic [1:0] { COND_BREAK, COND_IDENT, COND_IDENT_BYTES, COND_ERROR } lftm_cond_t;
    localparam lftm_rate_t RATE_RESET = RATE_9600; // rate preset after reset
    localparam lftm_cond_t COND_RESET = COND_BREAK; // condition after reset

    // settings written by the controller
    typedef struct packed {
        lftm_cond_t cond;
        logic [6:0] ident;
        logic [8:0] byte1;
        logic [8:0] byte2;
        lftm_rate_t rate;
        logic [14:0] custom;
    } lftm_cfg_t;

    // one decoded event from the receiver
    typedef struct packed {
        logic brk; // break field seen
        logic hdr; // identifier byte received
        logic dat; // data byte received
        logic err; // framing or sync error
        logic [7:0] value; // received byte
    } lftm_rx_t;
endpackage

// [design/lftm_rx.sv]
// module: oversampling lin byte receiver with break and sync detection
`timescale 1ns/10ps
module lftm_rx
(
    input wire logic clk, // system clock
    input wire logic rst_n, // sync reset, active low
    input wire logic tick, // one pulse per sixteenth of a bit
    input wire logic line, // observed lin line, high is recessive
    output lftm_pkg::lftm_rx_t ev_q // one-cycle decoded events
);
    typedef enum logic [2:0] { S_IDLE, S_START, S_BITS, S_STOP, S_HOLD } lftm_rxs_t;
    // ----------------------------------------
    // state
    // ----------------------------------------
    lftm_rxs_t st_q, st_d; // receiver state
    logic [3:0] ph_q, ph_d; // sub-bit phase
    logic [3:0] bit_q, bit_d; // bit index
    logic [7:0] sh_q, sh_d; // shift register
    logic [9:0] low_q, low_d; // dominant sub-bit tick counter
    logic [1:0] pos_q, pos_d; // 0 wait sync, 1 wait ident, 2 data
    logic [1:0] nd_q, nd_d; // data bytes seen in frame
    lftm_pkg::lftm_rx_t ev_d; // next events

    // next-state logic; bytes are lsb first as on the wire
    always_comb
    begin
        st_d = st_q;
        ph_d = ph_q;
        bit_d = bit_q;
        sh_d = sh_q;
        low_d = low_q;
        pos_d = pos_q;
        nd_d = nd_q;
        ev_d = '0;
        if (tick)
        begin
            // break watch runs beside the byte engine
            // counted in ticks, not byte-engine phases, which restart mid-break
            if (line)
                low_d = '0;
            else if (low_q != 10'h3FF)
                low_d = low_q + 10'h001;
            if (!line && low_q == {lftm_pkg::BREAK_BITS[5:0], 4'h0} - 10'h001)
            begin
                ev_d.brk = 1'b1;
                pos_d = 2'd0;
                nd_d = '0;
            end
            ph_d = ph_q + 4'h1;
            case (st_q)
                S_IDLE:
                begin
                    ph_d = '0;
                    if (!line)
                        st_d = S_START;
                end
                S_START:
                    // mid-bit check filters glitches
                    if (ph_q == 4'h7)
                    begin
                        ph_d = '0;
                        bit_d = '0;
                        st_d = line ? S_IDLE : S_BITS;
                    end
                S_BITS:
                    if (ph_q == 4'hF)
                    begin
                        sh_d = {line, sh_q[7:1]};
                        bit_d = bit_q + 4'h1;
                        if (bit_q == 4'h7)
                            st_d = S_STOP;
                    end
                S_STOP:
                    if (ph_q == 4'hF)
                    begin
                        st_d = S_IDLE;
                        ev_d.value = sh_q;
                        if (!line)
                        begin
                            // wait for recessive, else the rest of a break reads as bytes
                            st_d = S_HOLD;
                            // zero byte with low stop is the break itself
                            if (sh_q != 8'h00)
                                ev_d.err = 1'b1;
                        end
                        else if (pos_q == 2'd0)
                        begin
                            if (sh_q == 8'h55)
                                pos_d = 2'd1;
                            else
                                ev_d.err = 1'b1;
                        end
                        else if (pos_q == 2'd1)
                        begin
                            ev_d.hdr = 1'b1;
                            pos_d = 2'd2;
                        end
                        else if (nd_q != 2'd2)
                        begin
                            ev_d.dat = 1'b1;
                            nd_d = nd_q + 2'd1;
                        end
                    end
                S_HOLD:
                begin
                    // no new start bit until the line is released
                    ph_d = '0;
                    if (line)
                        st_d = S_IDLE;
                end
                default:
                    st_d = S_IDLE;
            endcase
        end
    end

    // registers only
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            st_q <= S_IDLE;
            ph_q <= '0;
            bit_q <= '0;
            sh_q <= '0;
            low_q <= '0;
            pos_q <= '0;
            nd_q <= '0;
            ev_q <= '0;
        end
        else
        begin
            st_q <= st_d;
            ph_q <= ph_d;
            bit_q <= bit_d;
            sh_q <= sh_d;
            low_q <= low_d;
            pos_q <= pos_d;
            nd_q <= nd_d;
            ev_q <= ev_d;
        end
    end
endmodule

// [design/lftm_top.sv]
// module: lin frame trigger settings store, readback and matcher
`timescale 1ns/10ps
module lftm_top
(
    input wire logic clk, // 10 mhz system clock
    input wire logic rst_n, // sync reset, active low
    input wire logic lin_line, // observed lin line
    input wire logic wr_cond, // write strobe for condition
    input wire logic wr_ident, // write strobe for identifier
    input wire logic wr_byte1, // write strobe for first byte
    input wire logic wr_byte2, // write strobe for second byte
    input wire logic wr_rate, // write strobe for rate
    input wire lftm_pkg::lftm_cfg_t wr_data, // values for the strobed setting
    output lftm_pkg::lftm_cfg_t settings_q, // stored settings readback
    output logic wr_reject_q, // last strobe checked, in order cond ident byte1 byte2 rate, was out of range
    output logic trigger_q // one-cycle trigger pulse
);
    // ----------------------------------------
    // settings store
    // ----------------------------------------
    lftm_pkg::lftm_cfg_t cfg_d; // next settings
    logic reject_d; // next reject flag

    // range-checked writes; bad values keep the old setting
    always_comb
    begin
        cfg_d = settings_q;
        reject_d = wr_reject_q;
        if (wr_cond)
        begin
            cfg_d.cond = wr_data.cond;
            reject_d = 1'b0;
        end
        if (wr_ident)
        begin
            reject_d = wr_data.ident > lftm_pkg::ID_DONT_CARE;
            if (!reject_d)
                cfg_d.ident = wr_data.ident;
        end
        if (wr_byte1)
        begin
            reject_d = wr_data.byte1 > lftm_pkg::BYTE_DONT_CARE;
            if (!reject_d)
                cfg_d.byte1 = wr_data.byte1;
        end
        if (wr_byte2)
        begin
            reject_d = wr_data.byte2 > lftm_pkg::BYTE_DONT_CARE;
            if (!reject_d)
                cfg_d.byte2 = wr_data.byte2;
        end
        if (wr_rate)
        begin
            // custom value checked only when custom is chosen
            reject_d = (wr_data.rate > lftm_pkg::RATE_CUSTOM) ||
                (wr_data.rate == lftm_pkg::RATE_CUSTOM &&
                (wr_data.custom < lftm_pkg::CUSTOM_MIN || wr_data.custom > lftm_pkg::CUSTOM_MAX));
            if (!reject_d)
            begin
                cfg_d.rate = wr_data.rate;
                if (wr_data.rate == lftm_pkg::RATE_CUSTOM)
                    cfg_d.custom = wr_data.custom;
            end
        end
    end

    // registers only
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            settings_q <= '{cond: lftm_pkg::COND_RESET, ident: lftm_pkg::ID_RESET,
                byte1: lftm_pkg::BYTE_RESET, byte2: lftm_pkg::BYTE_RESET,
                rate: lftm_pkg::RATE_RESET, custom: lftm_pkg::CUSTOM_RESET};
            wr_reject_q <= 1'b0;
        end
        else
        begin
            settings_q <= cfg_d;
            wr_reject_q <= reject_d;
        end
    end

    // ----------------------------------------
    // bit-rate divider
    // ----------------------------------------
    logic [15:0] div_q, div_d; // sample-tick counter
    logic [15:0] period; // clocks per sample tick
    logic [19:0] rate_bps; // selected bit rate
    logic tick; // oversample enable pulse

    // preset or custom rate; integer division rounds down the period
    always_comb
    begin
        case (settings_q.rate)
            lftm_pkg::RATE_600: rate_bps = 20'd600;
            lftm_pkg::RATE_1200: rate_bps = 20'd1200;
            lftm_pkg::RATE_2400: rate_bps = 20'd2400;
            lftm_pkg::RATE_4800: rate_bps = 20'd4800;
            lftm_pkg::RATE_9600: rate_bps = 20'd9600;
            lftm_pkg::RATE_19200: rate_bps = 20'd19200;
            default: rate_bps = {5'h0, settings_q.custom};
        endcase
        // a divider is costly but only changes on writes; fine at 10 mhz
        period = 16'(lftm_pkg::CLK_HZ / (lftm_pkg::OVERSAMPLE * 32'(rate_bps)));
        tick = (div_q == 16'h0000);
        div_d = tick ? period - 16'h0001 : div_q - 16'h0001;
    end

    // registers only
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            div_q <= '0;
        else
            div_q <= div_d;
    end

    // ----------------------------------------
    // receiver
    // ----------------------------------------
    lftm_pkg::lftm_rx_t ev; // decoded events

    lftm_rx u_rx
    (
        .clk(clk),
        .rst_n(rst_n),
        .tick(tick),
        .line(lin_line),
        .ev_q(ev)
    );

    // ----------------------------------------
    // matcher
    // ----------------------------------------
    logic id_ok_q, id_ok_d; // identifier matched this frame
    logic b1_ok_q, b1_ok_d; // first byte matched
    logic [1:0] nb_q, nb_d; // data byte index
    logic trig_d; // next trigger

    // compare fields as they arrive; ident is the low six bits
    always_comb
    begin
        id_ok_d = id_ok_q;
        b1_ok_d = b1_ok_q;
        nb_d = nb_q;
        trig_d = 1'b0;
        if (ev.brk)
        begin
            nb_d = '0;
            id_ok_d = 1'b0;
        end
        if (ev.hdr)
        begin
            id_ok_d = settings_q.ident == lftm_pkg::ID_DONT_CARE ||
                settings_q.ident[5:0] == ev.value[5:0];
            nb_d = '0;
        end
        case (settings_q.cond)
            lftm_pkg::COND_BREAK: trig_d = ev.brk;
            lftm_pkg::COND_IDENT: trig_d = ev.hdr && id_ok_d;
            lftm_pkg::COND_IDENT_BYTES:
                if (ev.dat)
                begin
                    nb_d = nb_q + 2'd1;
                    if (nb_q == 2'd0)
                        b1_ok_d = settings_q.byte1 == lftm_pkg::BYTE_DONT_CARE ||
                            settings_q.byte1[7:0] == ev.value;
                    else
                        // fires on second byte when all cared fields agree
                        trig_d = id_ok_q && b1_ok_q &&
                            (settings_q.byte2 == lftm_pkg::BYTE_DONT_CARE ||
                            settings_q.byte2[7:0] == ev.value);
                end
            lftm_pkg::COND_ERROR: trig_d = ev.err;
            default: trig_d = 1'b0;
        endcase
    end

    // registers only
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            id_ok_q <= 1'b0;
            b1_ok_q <= 1'b0;
            nb_q <= '0;
            trigger_q <= 1'b0;
        end
        else
        begin
            id_ok_q <= id_ok_d;
            b1_ok_q <= b1_ok_d;
            nb_q <= nb_d;
            trigger_q <= trig_d;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    property p_ident_range;
        @(posedge clk) disable iff (!rst_n) settings_q.ident <= lftm_pkg::ID_DONT_CARE;
    endproperty
    a_ident_range: assert property (p_ident_range) else $error("identifier out of range");

    property p_byte1_range;
        @(posedge clk) disable iff (!rst_n) settings_q.byte1 <= lftm_pkg::BYTE_DONT_CARE;
    endproperty
    a_byte1_range: assert property (p_byte1_range) else $error("first byte out of range");

    property p_byte2_range;
        @(posedge clk) disable iff (!rst_n) settings_q.byte2 <= lftm_pkg::BYTE_DONT_CARE;
    endproperty
    a_byte2_range: assert property (p_byte2_range) else $error("second byte out of range");

    property p_custom_range;
        @(posedge clk) disable iff (!rst_n)
            settings_q.custom >= lftm_pkg::CUSTOM_MIN && settings_q.custom <= lftm_pkg::CUSTOM_MAX;
    endproperty
    a_custom_range: assert property (p_custom_range) else $error("custom rate out of range");

    property p_ident_readback;
        @(posedge clk) disable iff (!rst_n)
            wr_ident && wr_data.ident <= lftm_pkg::ID_DONT_CARE |=> settings_q.ident == $past(wr_data.ident);
    endproperty
    a_ident_readback: assert property (p_ident_readback) else $error("identifier readback wrong");

    property p_rate_readback;
        @(posedge clk) disable iff (!rst_n)
            wr_rate && wr_data.rate < lftm_pkg::RATE_CUSTOM |=> settings_q.rate == $past(wr_data.rate);
    endproperty
    a_rate_readback: assert property (p_rate_readback) else $error("rate readback wrong");

    property p_ident_mode_only;
        @(posedge clk) disable iff (!rst_n)
            trigger_q && $past(ev.hdr) |-> $past(settings_q.cond) == lftm_pkg::COND_IDENT;
    endproperty
    a_ident_mode_only: assert property (p_ident_mode_only) else $error("ident trigger in wrong mode");

    property p_break_trig;
        @(posedge clk) disable iff (!rst_n)
            ev.brk && settings_q.cond == lftm_pkg::COND_BREAK |=> trigger_q;
    endproperty
    a_break_trig: assert property (p_break_trig) else $error("break did not trigger");

    property p_bytes_match;
        @(posedge clk) disable iff (!rst_n)
            trigger_q && $past(settings_q.cond) == lftm_pkg::COND_IDENT_BYTES |->
            $past(id_ok_q) && $past(b1_ok_q) && $past(ev.dat);
    endproperty
    a_bytes_match: assert property (p_bytes_match) else $error("bytes trigger without match");

    property p_rate_period;
        @(posedge clk) disable iff (!rst_n)
            settings_q.rate == lftm_pkg::RATE_9600 |-> period == 16'd65;
    endproperty
    a_rate_period: assert property (p_rate_period) else $error("preset rate period wrong");
endmodule

// [dv/lftm_lin_drv.sv]
// model: lin commander that drives the observed bus line
`timescale 1ns/10ps
module lftm_lin_drv
#(
    parameter int BIT_CLKS = 496 // clocks per bit, custom 20000 bit/s
)
(
    input wire logic clk, // system clock
    output logic line // lin bus, high is recessive
);
    // ----------------------------------------
    // bus idle level
    // ----------------------------------------
    // pull-up keeps the bus recessive between frames
    initial line = 1'b1;

    // ----------------------------------------
    // bit and byte timing
    // ----------------------------------------
    // one bit held for a full bit time, changed just after an edge
    task automatic send_bit(input logic b);
        line <= b;
        repeat (BIT_CLKS) @(posedge clk);
    endtask

    // start bit, eight bits lsb first, one stop bit
    task automatic send_byte(input logic [7:0] d);
        send_bit(1'b0);
        for (int i = 0; i < 8; i++)
            send_bit(d[i]);
        send_bit(1'b1);
    endtask

    // ----------------------------------------
    // whole frame
    // ----------------------------------------
    // break, delimiter, sync, optional protected id, up to two bytes
    task automatic frame(input logic [5:0] id, input logic hdr, input int nd,
        input logic [7:0] d1, input logic [7:0] d2);
        repeat (14) send_bit(1'b0);
        send_bit(1'b1);
        send_byte(8'h55);
        // parity bits filled in so a real frame is seen, not a bare id
        if (hdr)
            send_byte({~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id});
        if (nd > 0)
            send_byte(d1);
        if (nd > 1)
            send_byte(d2);
        send_bit(1'b1);
    endtask
endmodule

// [dv/lftm_tb.sv]
// testbench: settings writes, readback and frame triggers
`timescale 1ns/10ps
module testbench;
    typedef struct packed {
        lftm_pkg::lftm_cfg_t cfg; // expected readback
        logic rej; // expected reject flag
    } lftm_note_t;

    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic clk = 1'b0; // 10 mhz clock
    logic rst_n = 1'b0; // sync reset, active low
    logic lin_line; // driven by the line model
    logic [4:0] wr_sel = 5'h00; // strobes cond ident byte1 byte2 rate
    lftm_pkg::lftm_cfg_t wr_data = '0; // write values
    lftm_pkg::lftm_cfg_t settings_q; // readback
    logic wr_reject_q; // reject flag
    logic trigger_q; // trigger pulse
    lftm_pkg::lftm_cfg_t exp_cfg; // model of stored settings
    logic exp_rej = 1'b0; // model of reject flag
    lftm_note_t set_notes[$]; // pending readback notes
    logic trig_notes[$]; // pending trigger notes
    logic took = 1'b0; // a write was taken last edge
    logic peek = 1'b0; // bench asks for a plain readback check
    int n_fail = 0; // mismatches
    int n_checks = 0; // comparisons
    int cyc = 0; // cycle count for the timeout

    always #50 clk = ~clk;

    lftm_top dut (.clk(clk), .rst_n(rst_n), .lin_line(lin_line), .wr_cond(wr_sel[4]),
        .wr_ident(wr_sel[3]), .wr_byte1(wr_sel[2]), .wr_byte2(wr_sel[1]), .wr_rate(wr_sel[0]),
        .wr_data(wr_data), .settings_q(settings_q), .wr_reject_q(wr_reject_q), .trigger_q(trigger_q));
    lftm_lin_drv #(.BIT_CLKS(496)) drv (.clk(clk), .line(lin_line));

    // ----------------------------------------
    // compare and report
    // ----------------------------------------
    task automatic chk_set(input lftm_note_t n);
        n_checks++;
        if ({settings_q, wr_reject_q} !== n)
        begin
            n_fail++;
            $display("ERROR settings expected %h seen %h", n, {settings_q, wr_reject_q});
        end
    endtask

    task automatic chk_trig(input string what, input logic e, input logic g);
        n_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("ERROR %s expected %b seen %b", what, e, g);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ----------------------------------------
    // monitor: takes the oldest note when a result shows
    // ----------------------------------------
    // results are read at the falling edge, well after they settle
    always @(negedge clk)
    begin
        if ((took || peek) && set_notes.size() != 0)
            chk_set(set_notes.pop_front());
        if (trigger_q === 1'b1)
            chk_trig("trigger", trig_notes.size() != 0 ? trig_notes.pop_front() : 1'b0, 1'b1);
    end

    // write detector and hang guard, about 92k cycles expected
    always @(posedge clk)
    begin
        took <= |wr_sel;
        cyc <= cyc + 1;
        if (cyc == 95000)
        begin
            n_fail++;
            end_of_test();
        end
    end

    // ----------------------------------------
    // drivers
    // ----------------------------------------
    task automatic peek_now();
        set_notes.push_back({exp_cfg, exp_rej});
        peek <= 1'b1;
        @(posedge clk);
        peek <= 1'b0;
    endtask

    // pulse the strobes selected by sel for one cycle; out-of-range values leave the setting as it was
    task automatic wr(input logic [4:0] sel, input lftm_pkg::lftm_cfg_t v);
        exp_rej = (sel[3] && v.ident > 7'h40) || (sel[2] && v.byte1 > 9'h100)
            || (sel[1] && v.byte2 > 9'h100) || (sel[0] && (v.rate == 3'h7
            || (v.rate == lftm_pkg::RATE_CUSTOM && (v.custom < lftm_pkg::CUSTOM_MIN
            || v.custom > lftm_pkg::CUSTOM_MAX))));
        if (!exp_rej)
        begin
            if (sel[4]) exp_cfg.cond = v.cond;
            if (sel[3]) exp_cfg.ident = v.ident;
            if (sel[2]) exp_cfg.byte1 = v.byte1;
            if (sel[1]) exp_cfg.byte2 = v.byte2;
            if (sel[0]) exp_cfg.rate = v.rate;
            if (sel[0] && v.rate == lftm_pkg::RATE_CUSTOM) exp_cfg.custom = v.custom;
        end
        wr_sel <= sel;
        wr_data <= v;
        @(posedge clk);
        wr_sel <= 5'h00;
        set_notes.push_back({exp_cfg, exp_rej});
        @(posedge clk);
    endtask

    task automatic reset_dut(input int n);
        rst_n <= 1'b0;
        repeat (n) @(posedge clk);
        rst_n <= 1'b1;
        exp_cfg = '{lftm_pkg::COND_RESET, lftm_pkg::ID_RESET, lftm_pkg::BYTE_RESET,
            lftm_pkg::BYTE_RESET, lftm_pkg::RATE_RESET, lftm_pkg::CUSTOM_RESET};
        exp_rej = 1'b0;
        @(posedge clk);
        peek_now();
    endtask

    // program the matcher, send a frame, expect zero or one trigger
    task automatic scen(input lftm_pkg::lftm_cond_t c, input logic [6:0] idn, input logic [8:0] b1,
        input logic [8:0] b2, input logic [5:0] id, input logic hdr, input int nd, input logic fire);
        lftm_pkg::lftm_cfg_t v;
        v = '{c, idn, b1, b2, lftm_pkg::RATE_CUSTOM, 15'h4E20};
        wr(5'h1F, v);
        if (fire)
            trig_notes.push_back(1'b1);
        drv.frame(id, hdr, nd, 8'h12, 8'h34);
        chk_trig("trigger missing", 1'b0, trig_notes.size() != 0);
        $display("frame test cond %0d done", c);
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        lftm_pkg::lftm_cfg_t v;
        logic [6:0] idv[6];
        logic [8:0] bv[6];
        logic [14:0] cv[6];
        exp_cfg = '0;
        void'($urandom(23));
        reset_dut(12);
        v = exp_cfg;
        idv = '{7'h29, 7'h41, 7'h40, 7'h7F, 7'h00, 7'($urandom_range(63))};
        bv = '{9'h100, 9'h101, 9'h000, 9'h1FF, 9'h0FF, 9'($urandom_range(255))};
        cv = '{15'h012B, 15'h012C, 15'h4E21, 15'h4E20, 15'h01F4, 15'(300 + $urandom_range(19700))};
        for (int i = 0; i < 6; i++)
        begin
            v.ident = idv[i];
            wr(5'h08, v);
            v.byte1 = bv[i];
            wr(5'h04, v);
            v.byte2 = bv[5 - i];
            wr(5'h02, v);
            v.rate = lftm_pkg::RATE_CUSTOM;
            v.custom = cv[i];
            wr(5'h01, v);
        end
        $display("range test done");
        for (int i = 0; i < 8; i++)
        begin
            v.rate = lftm_pkg::lftm_rate_t'(i);
            v.custom = 15'h7FFF;
            wr(5'h01, v);
            v.cond = lftm_pkg::lftm_cond_t'(i);
            wr(5'h10, v);
        end
        $display("mode test done");
        reset_dut(2);
        scen(lftm_pkg::COND_BREAK, 7'h40, 9'h100, 9'h100, 6'h00, 1'b0, 0, 1'b1);
        scen(lftm_pkg::COND_IDENT, 7'h29, 9'h001, 9'h002, 6'h29, 1'b1, 0, 1'b1);
        scen(lftm_pkg::COND_IDENT_BYTES, 7'h40, 9'h012, 9'h034, 6'h2A, 1'b1, 2, 1'b1);
        scen(lftm_pkg::COND_IDENT_BYTES, 7'h2A, 9'h100, 9'h035, 6'h2A, 1'b1, 2, 1'b0);
        // error mode: byte 0x0f with a dominant stop bit must fire once
        v.cond = lftm_pkg::COND_ERROR;
        wr(5'h10, v);
        trig_notes.push_back(1'b1);
        drv.send_bit(1'b0);
        repeat (4) drv.send_bit(1'b1);
        repeat (6) drv.send_bit(1'b0);
        drv.send_bit(1'b1);
        chk_trig("error trigger missing", 1'b0, trig_notes.size() != 0);
        $display("error frame test done");
        end_of_test();
    end
endmodule
